// ===== rtl/tcc_top.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
// ==========================================================================
// Triple comparator control with reference generator settings.
module tcc_top
   import tcc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        idle_mode,
   input  wire logic [2:0]  cmp_raw,
   output logic      [2:0]  result_pin,
   output logic      [2:0]  result_pin_oe,
   output logic      [2:0]  cmp_power,
   output logic      [2:0]  noninverting_source_select,
   output logic      [5:0]  inverting_source_select,
   output logic             ref_power,
   output logic             range_select,
   output logic             supply_select,
   output logic      [3:0]  level_code,
   output logic             positive_pin_select,
   output logic      [1:0]  negative_ref_select,
   output logic             reference_pin_output_enable,
   output logic             irq
);
   logic [15:0] ctl_r [3];
   logic [15:0] ref_r;
   logic        idle_halt_r;
   logic [2:0]  irq_st_r;
   logic [2:0]  irq_msk_r;
   logic [2:0]  res;
   logic [2:0]  evt;
   logic [2:0]  evp;
   logic [2:0]  evt_clr;
   logic [2:0]  run;
   logic        halted;
   logic [15:0] stat;

   // Word index for a comparator control register, or 3 if none.
   function automatic logic [1:0] ctl_idx(input logic [7:0] a);
      case (a)
         `TCC_OFF_CTL1: ctl_idx = 2'h0;
         `TCC_OFF_CTL2: ctl_idx = 2'h1;
         `TCC_OFF_CTL3: ctl_idx = 2'h2;
         default:       ctl_idx = 2'h3;
      endcase
   endfunction

   assign halted = idle_halt_r & idle_mode;

   // ========================================================================
   // Per-channel units.
   for (genvar i = 0; i < 3; i++) begin : g_ch
      assign run[i] = ctl_r[i][`TCC_CTL_EN] & ~halted;
      // Software clears the event flag by writing zero to its bit.
      assign evt_clr[i] = wr && ctl_idx(addr) == 2'(i)
                          && !wdata[`TCC_CTL_EVT];
      tcc_cmp_unit u_ch (
         .core_clk     (core_clk),
         .nrst         (nrst),
         .raw_in       (cmp_raw[i]),
         .run          (run[i]),
         .invert       (ctl_r[i][`TCC_CTL_INV]),
         .edge_sel     (ctl_r[i][`TCC_CTL_EDGE_HI:`TCC_CTL_EDGE_LO]),
         .evt_clr      (evt_clr[i]),
         .result_bit_r (res[i]),
         .event_flag_r (evt[i]),
         .evt_pulse_r  (evp[i])
      );
   end

   // ========================================================================
   // Control registers; the event and result bits are not stored here.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctl_r[0] <= `TCC_RST_16;
         ctl_r[1] <= `TCC_RST_16;
         ctl_r[2] <= `TCC_RST_16;
      end else if (wr && ctl_idx(addr) != 2'h3) begin
         ctl_r[ctl_idx(addr)] <= wdata[15:0] & `TCC_CTL_WMASK;
      end
   end

   // Idle halt lives in the shared status register.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         idle_halt_r <= 1'b0;
      end else if (wr && addr == `TCC_OFF_STAT) begin
         idle_halt_r <= wdata[`TCC_ST_IDLE];
      end
   end

   // Reference control register.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ref_r <= `TCC_RST_16;
      end else if (wr && addr == `TCC_OFF_REF) begin
         ref_r <= wdata[15:0] & `TCC_REF_WMASK;
      end
   end

   // ========================================================================
   // Interrupt status: set wins over write-one-to-clear.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_st_r <= 3'h0;
      end else if (wr && addr == `TCC_OFF_IRQ_ST) begin
         irq_st_r <= (irq_st_r & ~wdata[2:0]) | evp;
      end else begin
         irq_st_r <= irq_st_r | evp;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_msk_r <= 3'h0;
      end else if (wr && addr == `TCC_OFF_IRQ_MSK) begin
         irq_msk_r <= wdata[2:0];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_st_r & irq_msk_r);
      end
   end

   // ========================================================================
   // Shared status view, mirrored live from the channels.
   always_comb begin
      stat = 16'h0000;
      stat[`TCC_ST_IDLE] = idle_halt_r;
      stat[`TCC_ST_EVT_LO +: 3] = evt;
      stat[`TCC_ST_RES_LO +: 3] = res;
   end

   // Read data stand in the cycle after the strobe only.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            `TCC_OFF_CTL1, `TCC_OFF_CTL2, `TCC_OFF_CTL3: begin
               rdata <= {16'h0000, ctl_r[ctl_idx(addr)]
                         | {6'h00, evt[ctl_idx(addr)],
                            res[ctl_idx(addr)], 8'h00}};
            end
            `TCC_OFF_STAT:    rdata <= {16'h0000, stat};
            `TCC_OFF_REF:     rdata <= {16'h0000, ref_r};
            `TCC_OFF_IRQ_ST:  rdata <= {29'h0, irq_st_r};
            `TCC_OFF_IRQ_MSK: rdata <= {29'h0, irq_msk_r};
            default:          rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // ========================================================================
   // Analog controls, registered. The result pin carries the registered
   // inversion bit, not the comparator output; the raw level goes to the pad.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         result_pin_oe <= 3'h0;
         cmp_power     <= 3'h0;
         noninverting_source_select <= 3'h0;
         inverting_source_select    <= 6'h00;
      end else begin
         for (int i = 0; i < 3; i++) begin
            result_pin_oe[i] <= ctl_r[i][`TCC_CTL_OE] & run[i];
            cmp_power[i]     <= run[i];
            noninverting_source_select[i] <=
               ctl_r[i][`TCC_CTL_NSEL];
            inverting_source_select[2*i +: 2] <=
               ctl_r[i][`TCC_CTL_ISEL_HI:`TCC_CTL_ISEL_LO];
         end
      end
   end

   // Pin value: polarity applied to the unsynchronised raw level is left to
   // the pad; here we register the inversion choice for it.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         result_pin <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            result_pin[i] <= ctl_r[i][`TCC_CTL_INV];
         end
      end
   end

   // Reference generator settings. Settling after a change is up to software.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ref_power           <= 1'b0;
         range_select        <= 1'b0;
         supply_select       <= 1'b0;
         level_code          <= 4'h0;
         positive_pin_select <= 1'b0;
         negative_ref_select <= 2'h0;
         reference_pin_output_enable <= 1'b0;
      end else begin
         ref_power           <= ref_r[`TCC_REF_EN];
         range_select        <= ref_r[`TCC_REF_RANGE];
         supply_select       <= ref_r[`TCC_REF_SUPPLY];
         level_code <= ref_r[`TCC_REF_LVL_HI:`TCC_REF_LVL_LO];
         positive_pin_select <= ref_r[`TCC_REF_PSEL];
         negative_ref_select <=
            ref_r[`TCC_REF_MSEL_HI:`TCC_REF_MSEL_LO];
         reference_pin_output_enable <= ref_r[`TCC_REF_OE];
      end
   end

   // ========================================================================
   // Checks.
   // Checked through the read path, so a broken read mux is caught too.
   a_evt_mirror: assert property (@(posedge core_clk) disable iff (!nrst)
      rd && addr == `TCC_OFF_STAT |=> rdata[10:8] == $past(evt))
      else $error("status event mirror mismatch");
   a_res_mirror: assert property (@(posedge core_clk) disable iff (!nrst)
      rd && addr == `TCC_OFF_STAT |=> rdata[2:0] == $past(res))
      else $error("status result mirror mismatch");
   a_idle_stop: assert property (@(posedge core_clk) disable iff (!nrst)
      idle_halt_r && idle_mode |=> !cmp_power[0] || !idle_mode)
      else $error("comparator running in idle with halt set");
   a_pin_oe: assert property (@(posedge core_clk) disable iff (!nrst)
      !ctl_r[0][`TCC_CTL_OE] |=> !result_pin_oe[0])
      else $error("result pin driven with output disabled");
   a_ref_oe: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(ref_r[`TCC_REF_OE]) |=> reference_pin_output_enable)
      else $error("reference pin enable not followed");
   a_irq_level: assert property (@(posedge core_clk) disable iff (!nrst)
      |(irq_st_r & irq_msk_r) |=> irq)
      else $error("interrupt not raised for unmasked status");
   a_isel_copy: assert property (@(posedge core_clk) disable iff (!nrst)
      ##1 inverting_source_select[1:0] == $past(ctl_r[0][1:0]))
      else $error("inverting select not forwarded");
   a_range_copy: assert property (@(posedge core_clk) disable iff (!nrst)
      ##1 range_select == $past(ref_r[`TCC_REF_RANGE]))
      else $error("range select not forwarded");
endmodule
`default_nettype wire

// ===== rtl/tcc_regs.svh
// How it works
// - Pin output enable set drives the registered inversion bit out while the comparator runs.
// - Each comparator has its own control register and stops when disabled.
// - Edge select 11 flags any output change while the event flag is clear.
// - Non-inverting select 1 takes the positive reference, 0 input pin A.
// - Inverting select 11 negative reference, 10 pin D, 01 pin C, 00 pin B.
// - Idle halt set stops all comparators in Idle; clear lets them run.
// - Status bits 10..8 mirror the three event flags.
// - Status bits 2..0 mirror the three result bits.
// - The reference has two ranges of sixteen levels set by a 4-bit code.
// - Range set spans 0..0.625 by 1/24; clear spans 0.25..0.719 by 1/32.
// - Supply select feeds the ladder from device rails or reference pins.
// - Positive pin select 1 uses the external positive pin, not the ladder.
// - The reference pin enable drives the level out, else disconnects it.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each).
`define TCC_OFF_CTL1    8'h00
`define TCC_OFF_CTL2    8'h04
`define TCC_OFF_CTL3    8'h08
`define TCC_OFF_STAT    8'h0c
`define TCC_OFF_REF     8'h10
`define TCC_OFF_IRQ_ST  8'h14
`define TCC_OFF_IRQ_MSK 8'h18
// ==========================================================================
// Comparator control fields.
`define TCC_CTL_EN      15
`define TCC_CTL_OE      14
`define TCC_CTL_INV     13
`define TCC_CTL_EVT     9
`define TCC_CTL_RES     8
`define TCC_CTL_EDGE_HI 7
`define TCC_CTL_EDGE_LO 6
`define TCC_CTL_NSEL    4
`define TCC_CTL_ISEL_HI 1
`define TCC_CTL_ISEL_LO 0
`define TCC_CTL_WMASK   16'he0d3
// ==========================================================================
// Status fields.
`define TCC_ST_IDLE     15
`define TCC_ST_EVT_LO   8
`define TCC_ST_RES_LO   0
// ==========================================================================
// Reference control fields.
`define TCC_REF_PSEL    10
`define TCC_REF_MSEL_HI 9
`define TCC_REF_MSEL_LO 8
`define TCC_REF_EN      7
`define TCC_REF_OE      6
`define TCC_REF_RANGE   5
`define TCC_REF_SUPPLY  4
`define TCC_REF_LVL_HI  3
`define TCC_REF_LVL_LO  0
`define TCC_REF_WMASK   16'h07ff
`define TCC_RST_16      16'h0000
`endif

// ===== rtl/tcc_pkg.sv
package tcc_pkg;
   typedef enum logic [1:0] {
      TCC_EDGE_NONE = 2'b00,
      TCC_EDGE_RISE = 2'b01,
      TCC_EDGE_FALL = 2'b10,
      TCC_EDGE_ANY  = 2'b11
   } tcc_edge_e;
   typedef enum logic [1:0] {
      TCC_INV_PIN_B = 2'b00,
      TCC_INV_PIN_C = 2'b01,
      TCC_INV_PIN_D = 2'b10,
      TCC_INV_REF_N = 2'b11
   } tcc_isel_e;
endpackage

// ===== rtl/tcc_cmp_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
// ==========================================================================
// One comparator channel: sync, polarity, edge detect, event flag.
module tcc_cmp_unit
   import tcc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       raw_in,
   input  wire logic       run,
   input  wire logic       invert,
   input  wire logic [1:0] edge_sel,
   input  wire logic       evt_clr,
   output logic            result_bit_r,
   output logic            event_flag_r,
   output logic            evt_pulse_r
);
   logic s1_r;
   logic s2_r;
   logic pol;
   logic rise;
   logic fall;
   logic hit;

   // Two flops first; only the second is ever read by logic.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end else begin
         s1_r <= raw_in;
         s2_r <= s1_r;
      end
   end

   assign pol  = s2_r ^ invert;
   assign rise = pol & ~result_bit_r;
   assign fall = ~pol & result_bit_r;

   // Edge choice on the polarity-adjusted result.
   always_comb begin
      case (tcc_edge_e'(edge_sel))
         TCC_EDGE_RISE: hit = rise;
         TCC_EDGE_FALL: hit = fall;
         TCC_EDGE_ANY:  hit = rise | fall;
         default:       hit = 1'b0;
      endcase
   end

   // Result holds its last value while stopped, so no spurious edges.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         result_bit_r <= 1'b0;
      end else if (run) begin
         result_bit_r <= pol;
      end
   end

   // A new event wins over a clear in the same cycle.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         event_flag_r <= 1'b0;
         evt_pulse_r  <= 1'b0;
      end else begin
         evt_pulse_r <= run & hit & ~event_flag_r;
         if (run && hit && !event_flag_r) begin
            event_flag_r <= 1'b1;
         end else if (evt_clr) begin
            event_flag_r <= 1'b0;
         end
      end
   end

   a_evt_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
      event_flag_r && !evt_clr |=> event_flag_r)
      else $error("event flag dropped without a clear");
   a_no_evt_stop: assert property (@(posedge core_clk) disable iff (!nrst)
      !run |=> !evt_pulse_r)
      else $error("event raised while stopped");
endmodule
`default_nettype wire

// ===== bench/tcc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
// ==========================================================================
// Self-checking bench for the triple comparator control block.
module tcc_top_bench
   import tcc_pkg::*;
;
   logic        core_clk;
   logic        nrst;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        idle_mode;
   logic [2:0]  cmp_raw;
   logic [2:0]  result_pin;
   logic [2:0]  result_pin_oe;
   logic [2:0]  cmp_power;
   logic [2:0]  noninverting_source_select;
   logic [5:0]  inverting_source_select;
   logic        ref_power;
   logic        range_select;
   logic        supply_select;
   logic [3:0]  level_code;
   logic        positive_pin_select;
   logic [1:0]  negative_ref_select;
   logic        reference_pin_output_enable;
   logic        irq;
   int          n_fail;
   int          checks_done;
   logic [31:0] d;

   // Every comparison goes through here so that unknowns never match.
   `define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
      n_fail++; $display("Error at %0t: got %h expected %h", $time, got, \
      exp); end end

   tcc_top uut (
      .core_clk                    (core_clk),
      .nrst                        (nrst),
      .addr                        (addr),
      .wdata                       (wdata),
      .wr                          (wr),
      .rd                          (rd),
      .rdata                       (rdata),
      .idle_mode                   (idle_mode),
      .cmp_raw                     (cmp_raw),
      .result_pin                  (result_pin),
      .result_pin_oe               (result_pin_oe),
      .cmp_power                   (cmp_power),
      .noninverting_source_select  (noninverting_source_select),
      .inverting_source_select     (inverting_source_select),
      .ref_power                   (ref_power),
      .range_select                (range_select),
      .supply_select               (supply_select),
      .level_code                  (level_code),
      .positive_pin_select         (positive_pin_select),
      .negative_ref_select         (negative_ref_select),
      .reference_pin_output_enable (reference_pin_output_enable),
      .irq                         (irq)
   );

   // ========================================================================
   // Clock at 250 MHz.
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ========================================================================
   // Bus tasks; strobes drop after one cycle so calls never collide.
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge core_clk);
      addr  <= a;
      wdata <= {16'h0000, v};
      wr    <= 1'b1;
      @(posedge core_clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   // Register outputs follow a write within two cycles.
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ========================================================================
   // Scenarios.
   task automatic t_reset;
      logic [7:0] a;
      for (int i = 0; i < 8; i++) begin
         a = 8'(i * 4);
         rd_reg(a, d);
         `CHECK(d, 32'h00000000)
      end
      `CHECK(cmp_power, 3'b000)
      `CHECK(irq, 1'b0)
      $display("reset test done");
   endtask

   task automatic t_enable_idle;
      wr_reg(`TCC_OFF_CTL1, 16'h8000);
      settle(3);
      `CHECK(cmp_power, 3'b001)
      `CHECK(result_pin_oe, 3'b000)
      idle_mode <= 1'b1;
      settle(3);
      `CHECK(cmp_power, 3'b001)
      wr_reg(`TCC_OFF_STAT, 16'h8000);
      settle(3);
      `CHECK(cmp_power, 3'b000)
      rd_reg(`TCC_OFF_STAT, d);
      `CHECK(d, 32'h00008000)
      idle_mode <= 1'b0;
      wr_reg(`TCC_OFF_CTL1, 16'hc000);
      settle(3);
      `CHECK(cmp_power, 3'b001)
      `CHECK(result_pin_oe, 3'b001)
      `CHECK(result_pin, 3'b000)
      wr_reg(`TCC_OFF_STAT, 16'h0000);
      wr_reg(`TCC_OFF_CTL1, 16'h0000);
      settle(3);
      `CHECK(cmp_power, 3'b000)
      `CHECK(result_pin_oe, 3'b000)
      $display("enable and idle test done");
   endtask

   task automatic t_routing;
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         wr_reg(`TCC_OFF_CTL2, {8'h80, 3'b000, c[0], 2'b00, c});
         settle(3);
         `CHECK(noninverting_source_select[1], c[0])
         `CHECK(inverting_source_select[3:2], c)
      end
      wr_reg(`TCC_OFF_CTL2, 16'h0000);
      $display("routing test done");
   endtask

   task automatic t_events;
      wr_reg(`TCC_OFF_IRQ_MSK, 16'h0000);
      wr_reg(`TCC_OFF_CTL1, 16'h80c0);
      settle(4);
      cmp_raw <= 3'b001;
      settle(10);
      `CHECK(irq, 1'b0)
      rd_reg(`TCC_OFF_IRQ_ST, d);
      `CHECK(d, 32'h00000001)
      rd_reg(`TCC_OFF_STAT, d);
      `CHECK(d, 32'h00000101)
      wr_reg(`TCC_OFF_IRQ_MSK, 16'h0001);
      settle(3);
      `CHECK(irq, 1'b1)
      wr_reg(`TCC_OFF_IRQ_ST, 16'h0001);
      settle(3);
      `CHECK(irq, 1'b0)
      // A second change while the flag is set must stay silent.
      cmp_raw <= 3'b000;
      settle(10);
      `CHECK(irq, 1'b0)
      rd_reg(`TCC_OFF_STAT, d);
      `CHECK(d, 32'h00000100)
      wr_reg(`TCC_OFF_CTL1, 16'h80c0);
      settle(3);
      rd_reg(`TCC_OFF_STAT, d);
      `CHECK(d, 32'h00000000)
      // Inverted, rising only: the raw fall is a reported rise.
      wr_reg(`TCC_OFF_CTL1, 16'ha040);
      settle(8);
      wr_reg(`TCC_OFF_CTL1, 16'ha040);
      // Flipping the polarity raised an event; clear its interrupt too.
      wr_reg(`TCC_OFF_IRQ_ST, 16'h0001);
      settle(3);
      `CHECK(irq, 1'b0)
      `CHECK(result_pin, 3'b001)
      rd_reg(`TCC_OFF_STAT, d);
      `CHECK(d, 32'h00000001)
      cmp_raw <= 3'b001;
      settle(10);
      rd_reg(`TCC_OFF_STAT, d);
      `CHECK(d, 32'h00000000)
      cmp_raw <= 3'b000;
      for (int n = 0; n < 20 && irq !== 1'b1; n++)
         settle(1);
      `CHECK(irq, 1'b1)
      rd_reg(`TCC_OFF_CTL1, d);
      `CHECK(d, 32'h0000a340)
      wr_reg(`TCC_OFF_CTL1, 16'h0000);
      wr_reg(`TCC_OFF_IRQ_ST, 16'h0007);
      settle(3);
      `CHECK(irq, 1'b0)
      $display("event test done");
   endtask

   task automatic t_reference;
      wr_reg(`TCC_OFF_REF, 16'hf535);
      settle(3);
      rd_reg(`TCC_OFF_REF, d);
      `CHECK(d, 32'h00000535)
      `CHECK(positive_pin_select, 1'b1)
      `CHECK(negative_ref_select, 2'b01)
      `CHECK(ref_power, 1'b0)
      `CHECK(reference_pin_output_enable, 1'b0)
      `CHECK(range_select, 1'b1)
      `CHECK(supply_select, 1'b1)
      `CHECK(level_code, 4'h5)
      wr_reg(`TCC_OFF_REF, 16'h02ca);
      settle(3); // Wait after a level change before use.
      `CHECK(positive_pin_select, 1'b0)
      `CHECK(negative_ref_select, 2'b10)
      `CHECK(ref_power, 1'b1)
      `CHECK(reference_pin_output_enable, 1'b1)
      `CHECK(range_select, 1'b0)
      `CHECK(supply_select, 1'b0)
      `CHECK(level_code, 4'ha)
      $display("reference test done");
   endtask

   // ========================================================================
   // Main sequence; reset is held for four cycles before any request.
   initial begin
      n_fail      = 0;
      checks_done = 0;
      nrst        = 1'b0;
      addr        = 8'h00;
      wdata       = 32'h00000000;
      wr          = 1'b0;
      rd          = 1'b0;
      idle_mode   = 1'b0;
      cmp_raw     = 3'b000;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_enable_idle();
      t_routing();
      t_events();
      t_reference();
      test_done();
   end
endmodule
`default_nettype wire
